// ### design/emr_pkg.sv
package emr_pkg;
    localparam int ADDR_W = 7;
    localparam logic [6:0] A_ACC_MODE = 7'h0F;
    localparam logic [6:0] A_PHASE_CAL = 7'h10;
    localparam logic [6:0] A_ZXTO = 7'h11;
    localparam logic [6:0] A_LINE_CYC = 7'h12;
    localparam logic [6:0] A_SAG_CYC = 7'h13;
    localparam logic [6:0] A_SAGTH = 7'h14;
    localparam logic [6:0] A_IPKTH = 7'h15;
    localparam logic [6:0] A_VPKTH = 7'h16;
    localparam logic [6:0] A_IPK = 7'h17;
    localparam logic [6:0] A_IPKCLR = 7'h18;
    localparam logic [6:0] A_VPK = 7'h19;
    localparam logic [6:0] A_VPKCLR = 7'h1A;
    localparam logic [6:0] A_GAIN = 7'h1B;
    localparam logic [6:0] A_RSV1C = 7'h1C;
    localparam logic [6:0] A_WGN = 7'h1D;
    localparam logic [6:0] A_VARGN = 7'h1E;
    localparam logic [6:0] A_VAGN = 7'h1F;
    localparam logic [6:0] A_WOFS = 7'h20;
    localparam logic [6:0] A_VAROFS = 7'h21;
    localparam logic [6:0] A_IRMSOFS = 7'h22;
    localparam logic [6:0] A_VRMSOFS = 7'h23;
    localparam logic [6:0] A_ACT_DIV = 7'h24;
    localparam logic [6:0] A_REACT_DIV = 7'h25;
    localparam logic [6:0] A_APP_DIV = 7'h26;
    localparam logic [6:0] A_P1NUM = 7'h27;
    localparam logic [6:0] A_P1DEN = 7'h28;
    localparam logic [6:0] A_P2NUM = 7'h29;
    localparam logic [6:0] A_P2DEN = 7'h2A;
    localparam logic [6:0] A_RSV_LO = 7'h3B;
    localparam logic [6:0] A_RSV_HI = 7'h3F;
    localparam logic [6:0] A_RSV3C = 7'h3C;
    localparam int PTR_DIR_BIT = 7;
    localparam logic [7:0] R_PHASE_CAL = 8'h40;
    localparam logic [11:0] R_ZXTO = 12'hFFF;
    localparam logic [15:0] R_LINE_CYC = 16'hFFFF;
    localparam logic [7:0] R_SAG_CYC = 8'hFF;
    localparam logic [15:0] R_PKTH = 16'hFFFF;
    localparam logic [15:0] R_DEN = 16'h003F;
    localparam logic [15:0] R_RSV3C = 16'h0300;
    localparam int CLK_HZ = 40000000;
    localparam int CORE_HZ = 819200;
    localparam int CORE_DIV = CLK_HZ / CORE_HZ;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    typedef enum logic {ST_IDLE = 1'b0, ST_PEND = 1'b1} emr_state_e;

    typedef struct packed {
        logic [7:0] accumulation_mode_cfg;
        logic [7:0] phase_calibration;
        logic [11:0] zero_cross_timeout;
        logic [15:0] line_cycle_count;
        logic [7:0] sag_cycle_count;
        logic [15:0] sag_threshold;
        logic [15:0] current_peak_threshold;
        logic [15:0] voltage_peak_threshold;
        logic [7:0] input_gain_select;
        logic [11:0] active_power_gain;
        logic [11:0] reactive_power_gain;
        logic [11:0] apparent_power_gain;
        logic [15:0] active_power_offset;
        logic [15:0] reactive_power_offset;
        logic [11:0] current_rms_offset;
        logic [11:0] voltage_rms_offset;
        logic [7:0] active_energy_divider;
        logic [7:0] reactive_energy_divider;
        logic [7:0] apparent_energy_divider;
        logic [15:0] pulse1_numerator;
        logic [15:0] pulse1_denominator;
        logic [15:0] pulse2_numerator;
        logic [15:0] pulse2_denominator;
    } emr_cfg_s;

    typedef struct packed {
        logic valid;
        logic [23:0] level;
    } emr_peak_s;
endpackage

// ### design/emr_regs.sv
`timescale 1ns/1ps
module emr_regs #(
    parameter int DIV = emr_pkg::CORE_DIV
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ptr_wr,
    input wire logic [7:0] ptr_in,
    input wire logic [2:0] dat_wr,
    input wire logic [7:0] dat_in,
    input wire emr_pkg::emr_peak_s cur_peak_in,
    input wire emr_pkg::emr_peak_s volt_peak_in,
    output logic [7:0] meter_pointer_byte,
    output logic [7:0] meter_data_low,
    output logic [7:0] meter_data_mid,
    output logic [7:0] meter_data_high,
    output logic busy,
    output emr_pkg::emr_cfg_s cfg,
    output logic [23:0] current_peak_value,
    output logic [23:0] voltage_peak_value
);
    logic [7:0] div_cnt;
    logic core_tick;
    emr_pkg::emr_state_e state;
    logic [11:0] reserved_1c;
    logic [15:0] rsv_tail [0:4];
    logic do_wr;
    logic do_rd;
    logic [6:0] addr;
    logic [23:0] wdat;
    logic [23:0] rd_val;
    logic clr_ipk;
    logic clr_vpk;

    // Slow core rate as an enable; register reads and writes land on it, pointer, host data byte writes and peak captures do not
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_cnt <= 8'h00;
            core_tick <= 1'b0;
        end else if (div_cnt == 8'(DIV - 1)) begin
            div_cnt <= 8'h00;
            core_tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 8'h01;
            core_tick <= 1'b0;
        end
    end

    // A pointer write arms one access executed on the next core tick
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= emr_pkg::ST_IDLE;
            meter_pointer_byte <= 8'h00;
            busy <= 1'b0;
        end else begin
            case (state)
                emr_pkg::ST_IDLE: begin
                    if (ptr_wr) begin
                        meter_pointer_byte <= ptr_in;
                        state <= emr_pkg::ST_PEND;
                        busy <= 1'b1;
                    end
                end
                emr_pkg::ST_PEND: begin
                    // Pointer writes while busy are dropped; the host must wait
                    if (core_tick) begin
                        state <= emr_pkg::ST_IDLE;
                        busy <= 1'b0;
                    end
                end
                default: begin
                    state <= emr_pkg::ST_IDLE;
                    busy <= 1'b0;
                end
            endcase
        end
    end

    assign addr = meter_pointer_byte[6:0];
    assign do_wr = (state == emr_pkg::ST_PEND) && core_tick
        && meter_pointer_byte[emr_pkg::PTR_DIR_BIT];
    assign do_rd = (state == emr_pkg::ST_PEND) && core_tick
        && !meter_pointer_byte[emr_pkg::PTR_DIR_BIT];
    assign wdat = {meter_data_high, meter_data_mid, meter_data_low};
    assign clr_ipk = do_rd && (addr == emr_pkg::A_IPKCLR);
    assign clr_vpk = do_rd && (addr == emr_pkg::A_VPKCLR);

    function automatic logic [23:0] peak_next(
        input logic [23:0] cur,
        input emr_pkg::emr_peak_s smp,
        input logic clr
    );
        logic [23:0] base;
        base = clr ? 24'h000000 : cur;
        // A sample arriving with the clear still lands: capture wins over clear
        if (smp.valid && smp.level > base) begin
            peak_next = smp.level;
        end else begin
            peak_next = base;
        end
    endfunction

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            current_peak_value <= 24'h000000;
            voltage_peak_value <= 24'h000000;
        end else begin
            current_peak_value <= peak_next(current_peak_value, cur_peak_in, clr_ipk);
            voltage_peak_value <= peak_next(voltage_peak_value, volt_peak_in, clr_vpk);
        end
    end

    // Data bytes: a completed read overrides host byte writes in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meter_data_low <= 8'h00;
            meter_data_mid <= 8'h00;
            meter_data_high <= 8'h00;
        end else if (do_rd) begin
            meter_data_low <= rd_val[7:0];
            meter_data_mid <= rd_val[15:8];
            meter_data_high <= rd_val[23:16];
        end else begin
            if (dat_wr[0]) begin
                meter_data_low <= dat_in;
            end
            if (dat_wr[1]) begin
                meter_data_mid <= dat_in;
            end
            if (dat_wr[2]) begin
                meter_data_high <= dat_in;
            end
        end
    end

    // Narrow registers zero-extend, so unused upper bytes read as zero
    always_comb begin
        rd_val = 24'h000000;
        case (addr)
            emr_pkg::A_ACC_MODE: rd_val = {16'h0000, cfg.accumulation_mode_cfg};
            emr_pkg::A_PHASE_CAL: rd_val = {16'h0000, cfg.phase_calibration};
            emr_pkg::A_ZXTO: rd_val = {12'h000, cfg.zero_cross_timeout};
            emr_pkg::A_LINE_CYC: rd_val = {8'h00, cfg.line_cycle_count};
            emr_pkg::A_SAG_CYC: rd_val = {16'h0000, cfg.sag_cycle_count};
            emr_pkg::A_SAGTH: rd_val = {8'h00, cfg.sag_threshold};
            emr_pkg::A_IPKTH: rd_val = {8'h00, cfg.current_peak_threshold};
            emr_pkg::A_VPKTH: rd_val = {8'h00, cfg.voltage_peak_threshold};
            emr_pkg::A_IPK, emr_pkg::A_IPKCLR: rd_val = current_peak_value;
            emr_pkg::A_VPK, emr_pkg::A_VPKCLR: rd_val = voltage_peak_value;
            emr_pkg::A_GAIN: rd_val = {16'h0000, cfg.input_gain_select};
            emr_pkg::A_RSV1C: rd_val = {12'h000, reserved_1c};
            emr_pkg::A_WGN: rd_val = {12'h000, cfg.active_power_gain};
            emr_pkg::A_VARGN: rd_val = {12'h000, cfg.reactive_power_gain};
            emr_pkg::A_VAGN: rd_val = {12'h000, cfg.apparent_power_gain};
            emr_pkg::A_WOFS: rd_val = {8'h00, cfg.active_power_offset};
            emr_pkg::A_VAROFS: rd_val = {8'h00, cfg.reactive_power_offset};
            emr_pkg::A_IRMSOFS: rd_val = {12'h000, cfg.current_rms_offset};
            emr_pkg::A_VRMSOFS: rd_val = {12'h000, cfg.voltage_rms_offset};
            emr_pkg::A_ACT_DIV: rd_val = {16'h0000, cfg.active_energy_divider};
            emr_pkg::A_REACT_DIV: rd_val = {16'h0000, cfg.reactive_energy_divider};
            emr_pkg::A_APP_DIV: rd_val = {16'h0000, cfg.apparent_energy_divider};
            emr_pkg::A_P1NUM: rd_val = {8'h00, cfg.pulse1_numerator};
            emr_pkg::A_P1DEN: rd_val = {8'h00, cfg.pulse1_denominator};
            emr_pkg::A_P2NUM: rd_val = {8'h00, cfg.pulse2_numerator};
            emr_pkg::A_P2DEN: rd_val = {8'h00, cfg.pulse2_denominator};
            default: begin
                // Bounded on both sides so addresses above the tail cannot alias into it
                if (addr >= emr_pkg::A_RSV_LO && addr <= emr_pkg::A_RSV_HI) begin
                    rd_val = {8'h00, rsv_tail[3'(addr - emr_pkg::A_RSV_LO)]};
                end
            end
        endcase
    end

    // Writes take the low bits of the data bytes; unmapped ones are ignored
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg.accumulation_mode_cfg <= 8'h00;
            cfg.phase_calibration <= emr_pkg::R_PHASE_CAL;
            cfg.zero_cross_timeout <= emr_pkg::R_ZXTO;
            cfg.line_cycle_count <= emr_pkg::R_LINE_CYC;
            cfg.sag_cycle_count <= emr_pkg::R_SAG_CYC;
            cfg.sag_threshold <= 16'h0000;
            cfg.current_peak_threshold <= emr_pkg::R_PKTH;
            cfg.voltage_peak_threshold <= emr_pkg::R_PKTH;
            cfg.input_gain_select <= 8'h00;
            cfg.active_power_gain <= 12'h000;
            cfg.reactive_power_gain <= 12'h000;
            cfg.apparent_power_gain <= 12'h000;
            cfg.active_power_offset <= 16'h0000;
            cfg.reactive_power_offset <= 16'h0000;
            cfg.current_rms_offset <= 12'h000;
            cfg.voltage_rms_offset <= 12'h000;
            cfg.active_energy_divider <= 8'h00;
            cfg.reactive_energy_divider <= 8'h00;
            cfg.apparent_energy_divider <= 8'h00;
            cfg.pulse1_numerator <= 16'h0000;
            cfg.pulse1_denominator <= emr_pkg::R_DEN;
            cfg.pulse2_numerator <= 16'h0000;
            cfg.pulse2_denominator <= emr_pkg::R_DEN;
            reserved_1c <= 12'h000;
            for (int i = 0; i < 5; i++) begin
                rsv_tail[i] <= 16'h0000;
            end
            rsv_tail[1] <= emr_pkg::R_RSV3C;
        end else if (do_wr) begin
            case (addr)
                emr_pkg::A_ACC_MODE: cfg.accumulation_mode_cfg <= wdat[7:0];
                emr_pkg::A_PHASE_CAL: cfg.phase_calibration <= wdat[7:0];
                emr_pkg::A_ZXTO: cfg.zero_cross_timeout <= wdat[11:0];
                emr_pkg::A_LINE_CYC: cfg.line_cycle_count <= wdat[15:0];
                emr_pkg::A_SAG_CYC: cfg.sag_cycle_count <= wdat[7:0];
                emr_pkg::A_SAGTH: cfg.sag_threshold <= wdat[15:0];
                emr_pkg::A_IPKTH: cfg.current_peak_threshold <= wdat[15:0];
                emr_pkg::A_VPKTH: cfg.voltage_peak_threshold <= wdat[15:0];
                emr_pkg::A_GAIN: cfg.input_gain_select <= wdat[7:0];
                emr_pkg::A_RSV1C: reserved_1c <= wdat[11:0];
                emr_pkg::A_WGN: cfg.active_power_gain <= wdat[11:0];
                emr_pkg::A_VARGN: cfg.reactive_power_gain <= wdat[11:0];
                emr_pkg::A_VAGN: cfg.apparent_power_gain <= wdat[11:0];
                emr_pkg::A_WOFS: cfg.active_power_offset <= wdat[15:0];
                emr_pkg::A_VAROFS: cfg.reactive_power_offset <= wdat[15:0];
                emr_pkg::A_IRMSOFS: cfg.current_rms_offset <= wdat[11:0];
                emr_pkg::A_VRMSOFS: cfg.voltage_rms_offset <= wdat[11:0];
                emr_pkg::A_ACT_DIV: cfg.active_energy_divider <= wdat[7:0];
                emr_pkg::A_REACT_DIV: cfg.reactive_energy_divider <= wdat[7:0];
                emr_pkg::A_APP_DIV: cfg.apparent_energy_divider <= wdat[7:0];
                emr_pkg::A_P1NUM: cfg.pulse1_numerator <= wdat[15:0];
                emr_pkg::A_P1DEN: cfg.pulse1_denominator <= wdat[15:0];
                emr_pkg::A_P2NUM: cfg.pulse2_numerator <= wdat[15:0];
                emr_pkg::A_P2DEN: cfg.pulse2_denominator <= wdat[15:0];
                default: begin
                    // Tail stays writable so a bad write can be undone
                    if (addr >= emr_pkg::A_RSV_LO && addr <= emr_pkg::A_RSV_HI) begin
                        rsv_tail[3'(addr - emr_pkg::A_RSV_LO)] <= wdat[15:0];
                    end
                end
            endcase
        end
    end
endmodule

// ### dv/emr_regs_sva.sv
`timescale 1ns/1ps
module emr_regs_chk #(
    parameter int DIV = 48
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ptr_wr,
    input wire logic [7:0] ptr_in,
    input wire logic [2:0] dat_wr,
    input wire logic [7:0] dat_in,
    input wire emr_pkg::emr_peak_s cur_peak_in,
    input wire emr_pkg::emr_peak_s volt_peak_in,
    input wire logic [7:0] meter_pointer_byte,
    input wire logic [7:0] meter_data_low,
    input wire logic [7:0] meter_data_mid,
    input wire logic [7:0] meter_data_high,
    input wire logic busy,
    input wire emr_pkg::emr_cfg_s cfg,
    input wire logic [23:0] current_peak_value,
    input wire logic [23:0] voltage_peak_value
);
    localparam int BMAX = DIV + 2;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic busy_q;
    logic rd_done;
    logic [6:0] pa;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= busy;
        end
    end
    assign pa = meter_pointer_byte[6:0];
    assign rd_done = busy_q && !busy && !meter_pointer_byte[7];
    take_ptr_a: assert property (ptr_wr && !busy |=> busy && meter_pointer_byte == $past(ptr_in))
        else $error("pointer not taken");
    refuse_ptr_a: assert property (ptr_wr && busy |=> $stable(meter_pointer_byte))
        else $error("pointer taken while busy");
    busy_bound_a: assert property ($rose(busy) |-> ##[1:BMAX] !busy)
        else $error("access never completes");
    cfg_hold_a: assert property (!busy |=> $stable(cfg))
        else $error("config changed with no access");
    read_keep_a: assert property (rd_done |-> $stable(cfg))
        else $error("read changed config");
    byte_pad_a: assert property (rd_done && pa inside {7'h0F, 7'h10, 7'h13, 7'h1B, [7'h24:7'h26]}
        |-> {meter_data_high, meter_data_mid} == 16'h0000)
        else $error("upper bytes not zeroed");
    ipk_clear_a: assert property (rd_done && pa == 7'h18 && !$past(cur_peak_in.valid)
        |-> current_peak_value == 24'h000000) else $error("current peak not cleared");
    vpk_clear_a: assert property (rd_done && pa == 7'h1A && !$past(volt_peak_in.valid)
        |-> voltage_peak_value == 24'h000000) else $error("voltage peak not cleared");
    ipk_keep_a: assert property (rd_done && pa == 7'h17 && !$past(cur_peak_in.valid)
        |-> $stable(current_peak_value)) else $error("current peak disturbed");
    vpk_keep_a: assert property (rd_done && pa == 7'h19 && !$past(volt_peak_in.valid)
        |-> $stable(voltage_peak_value)) else $error("voltage peak disturbed");
    gap_read_a: assert property (rd_done && pa inside {[7'h2B:7'h3A], [7'h40:7'h7F]}
        |-> {meter_data_high, meter_data_mid, meter_data_low} == 24'h000000)
        else $error("unmapped read not zero");
endmodule
bind emr_regs emr_regs_chk #(.DIV(DIV)) chk (.clk(clk), .rst(rst), .ptr_wr(ptr_wr),
    .ptr_in(ptr_in), .dat_wr(dat_wr), .dat_in(dat_in), .cur_peak_in(cur_peak_in),
    .volt_peak_in(volt_peak_in), .meter_pointer_byte(meter_pointer_byte),
    .meter_data_low(meter_data_low), .meter_data_mid(meter_data_mid),
    .meter_data_high(meter_data_high), .busy(busy), .cfg(cfg),
    .current_peak_value(current_peak_value), .voltage_peak_value(voltage_peak_value));

// ### dv/emr_host.sv
`timescale 1ns/1ps
module emr_host (
    input wire logic clk,
    input wire logic busy,
    output logic ptr_wr,
    output logic [7:0] ptr_in,
    output logic [2:0] dat_wr,
    output logic [7:0] dat_in
);
    initial begin
        ptr_wr = 1'b0;
        ptr_in = 8'h00;
        dat_wr = 3'b000;
        dat_in = 8'h00;
    end
    // Poke sends a stray pointer while busy; only the refusal case uses it
    task automatic point(input logic [7:0] p, input logic poke);
        ptr_in = p;
        ptr_wr = 1'b1;
        @(negedge clk);
        ptr_in = ~p;
        ptr_wr = poke;
        @(negedge clk);
        ptr_wr = 1'b0;
        // A stuck access is left to the bench watchdog, which fails the run
        while (busy === 1'b1) begin
            @(negedge clk);
        end
        repeat (2) @(negedge clk);
    endtask
    task automatic wr(input logic [6:0] a, input logic [23:0] v);
        if (a == 7'h1C || (a >= 7'h3B && a <= 7'h3F)) return;
        for (int i = 0; i < 3; i++) begin
            dat_wr = 3'b001 << i;
            dat_in = v[8*i +: 8];
            @(negedge clk);
        end
        dat_wr = 3'b000;
        dat_in = ~dat_in;
        point({1'b1, a}, 1'b0);
    endtask
endmodule

// ### dv/tb.sv
`timescale 1ns/1ps
module tb;
    logic clk, rst, ptr_wr, busy;
    logic [7:0] ptr_in, dat_in, mp, md_l, md_m, md_h;
    logic [2:0] dat_wr;
    emr_pkg::emr_peak_s cur_pk, volt_pk;
    emr_pkg::emr_cfg_s cfg;
    logic [23:0] ipk, vpk, d, v;
    logic [31:0] seed;
    int miscompares, checked;
    emr_regs #(.DIV(4)) dut (.clk(clk), .rst(rst), .ptr_wr(ptr_wr), .ptr_in(ptr_in),
        .dat_wr(dat_wr), .dat_in(dat_in), .cur_peak_in(cur_pk), .volt_peak_in(volt_pk),
        .meter_pointer_byte(mp), .meter_data_low(md_l), .meter_data_mid(md_m),
        .meter_data_high(md_h), .busy(busy), .cfg(cfg), .current_peak_value(ipk),
        .voltage_peak_value(vpk));
    emr_host host (.clk(clk), .busy(busy), .ptr_wr(ptr_wr), .ptr_in(ptr_in),
        .dat_wr(dat_wr), .dat_in(dat_in));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [23:0] rv(input logic [6:0] a);
        case (a)
            7'h10: return 24'h000040;
            7'h11: return 24'h000FFF;
            7'h12, 7'h15, 7'h16: return 24'h00FFFF;
            7'h13: return 24'h0000FF;
            7'h28, 7'h2A: return 24'h00003F;
            7'h3C: return 24'h000300;
            default: return 24'h000000;
        endcase
    endfunction
    function automatic logic [23:0] msk(input logic [6:0] a);
        case (a)
            7'h0F, 7'h10, 7'h13, 7'h1B, 7'h24, 7'h25, 7'h26: return 24'h0000FF;
            7'h11, 7'h1D, 7'h1E, 7'h1F, 7'h22, 7'h23: return 24'h000FFF;
            default: return 24'h00FFFF;
        endcase
    endfunction
    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rd(input logic [6:0] a, input logic poke, output logic [23:0] q);
        host.point({1'b0, a}, poke);
        q = {md_h, md_m, md_l};
    endtask
    task automatic end_of_test;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        #(25 * 30000);
        miscompares++;
        end_of_test();
    end
    initial begin
        rst = 1'b1;
        cur_pk = '0;
        volt_pk = '0;
        seed = 32'h5972D52C;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        for (int a = 'h0F; a <= 'h3F; a++) begin
            if (a > 'h2A && a < 'h3B) continue;
            rd(7'(a), 1'b0, d);
            chk("reset value", rv(7'(a)), d);
        end
        for (int a = 'h0F; a <= 'h2A; a++) begin
            if ((a >= 'h17 && a <= 'h1A) || a == 'h1C) continue;
            seed = lfsr(seed);
            v = (a == 'h0F) ? 24'hFFFFFF : seed[23:0];
            host.wr(7'(a), v);
            rd(7'(a), 1'b0, d);
            chk("readback", v & msk(7'(a)), d);
        end
        chk("cfg output", v & 24'h00FFFF, {8'h00, cfg.pulse2_denominator});
        host.wr(7'h2B, 24'hA5A5A5);
        rd(7'h2B, 1'b1, d);
        chk("unmapped", 24'h000000, d);
        chk("pointer", 24'h00002B, {16'h0000, mp});
        host.wr(7'h43, 24'h5A5A5A);
        rd(7'h43, 1'b0, d);
        chk("unmapped high", 24'h000000, d);
        rd(7'h3B, 1'b0, d);
        chk("reserved alias", 24'h000000, d);
        seed = lfsr(seed);
        cur_pk = {1'b1, seed[23:0]};
        volt_pk = {1'b1, seed[31:8]};
        @(negedge clk);
        cur_pk.valid = 1'b0;
        volt_pk.valid = 1'b0;
        for (int k = 0; k < 2; k++) begin
            v = (k == 0) ? seed[23:0] : seed[31:8];
            rd(7'(8'h17 + 2 * k), 1'b0, d);
            chk("peak", v, d);
            rd(7'(8'h18 + 2 * k), 1'b0, d);
            chk("peak clear read", v, d);
            rd(7'(8'h17 + 2 * k), 1'b0, d);
            chk("peak after clear", 24'h000000, d);
        end
        chk("peak outputs", 24'h000000, ipk | vpk);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        rd(7'h0F, 1'b0, d);
        chk("second reset mode", 24'h000000, d);
        rd(7'h28, 1'b0, d);
        chk("second reset den1", 24'h00003F, d);
        rd(7'h2A, 1'b0, d);
        chk("second reset den2", 24'h00003F, d);
        end_of_test();
    end
endmodule
